// File: logic/ebm_pkg.sv
// Shared constants and types of the external bus master cycle logic.
package ebm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // System clock period in nanoseconds.
  localparam int SYS_PERIOD_NS = 10;
  // Half period of the external bus clock in nanoseconds.
  localparam int BUS_HALF_NS   = 40;
  // Half bus clock in system cycles, rounded up.
  localparam int BUS_HALF_CYC  = (BUS_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ---------------------------------------------------------------
  // Transfer size codes (bytes still to move)
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_LONG  = 2'h0;
  localparam logic [1:0] SZ_BYTE  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;

  // ---------------------------------------------------------------
  // Address space codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SPC_USER_DATA = 3'h1;
  localparam logic [2:0] SPC_USER_PROG = 3'h2;
  localparam logic [2:0] SPC_SUP_DATA  = 3'h5;
  localparam logic [2:0] SPC_SUP_PROG  = 3'h6;
  localparam logic [2:0] SPC_CONTROL   = 3'h7;

  // ---------------------------------------------------------------
  // Reset values and acknowledge encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] RST_SPACE     = 3'h0;
  // Acknowledge pair {word, byte}, active low.
  localparam logic [1:0] ACK_NONE      = 2'h3;
  localparam logic [1:0] ACK_BYTE_PORT = 2'h2;

  // Half-clock states of one bus cycle.
  typedef enum {ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5} ebm_state_t;

endpackage

// File: logic/ebm_xfer_if.sv
// Interface between the cycle sequencer and the operand size calculator.
`timescale 1ns/1ns
interface ebm_xfer_if;
  logic [2:0] rem;        // Bytes still to move in the operand.
  logic       a0;         // Low address bit of the current cycle.
  logic       port8;      // Port answered as 8 bits wide.
  logic [1:0] size_code;  // Size code driven on the bus.
  logic [2:0] moved;      // Bytes moved when the cycle ends.
  modport calc (input rem, a0, port8, output size_code, moved);
  modport user (output rem, a0, port8, input size_code, moved);
endinterface

// File: logic/ebm_size_calc.sv
// Size code and bytes-moved calculation for one bus cycle.
`timescale 1ns/1ns
module ebm_size_calc
  import ebm_pkg::*;
(
  ebm_xfer_if.calc x
);

  // The size code is the remaining count modulo four; a byte port, an
  // odd address or a single byte left moves one byte, else two.
  always_comb begin
    x.size_code = x.rem[1:0];
    if (x.port8 || x.a0 || (x.rem == 3'h1)) begin
      x.moved = 3'h1;
    end else begin
      x.moved = 3'h2;
    end
  end

endmodule // ebm_size_calc

// File: logic/ebm_in_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ns
module ebm_in_sync
  import ebm_pkg::*;
#(
  parameter int W = 1
) (
  input  logic         i_sys_clk,
  input  logic         i_sys_rst,
  input  logic [W-1:0] i_async,
  input  logic [W-1:0] i_rst_val,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;  // First stage, read only by the second.
  logic [W-1:0] sync_reg;  // Second stage, resolved level.

  // Both stages load the idle level under reset, so a changing pin
  // settles to a clean 0 or 1 before anything looks at it.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      meta_reg <= i_rst_val;
      sync_reg <= i_rst_val;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // ebm_in_sync

// File: logic/ebm_bus_master.sv
// Bus-master cycle sequencer of the external parallel bus.
`timescale 1ns/1ns
// Function
// [R1] Word and long operands only at even addresses.
// [R2] Byte port splits wide operands into cycles.
// [R3] Slave port is 8 or 16 bits.
// [R4] Slave sets cycle length via acknowledges.
// [R5] Asynchronous mode synchronises inputs, adding latency.
// [R6] Synchronous mode completes cycle in three clocks.
// [R7] Fast termination finishes access in two clocks.
// [R8] Inputs sampled at falling bus clock edge.
// [R9] Sampled inputs resolve to clean logic levels.
// [R10] Drive address, size, space, direction during strobe.
// [R11] Size code gives remaining bytes of operand.
// [R12] Direction changes only between read and write.
// [R13] Locked output spans whole read-modify-write sequence.
// [R14] Three-bit space code selects eight spaces.
// [R15] Privileged state selects supervisor space codes.
// [R16] Address gives byte or most significant byte.
// [R17] Address strobe half clock after start.
// [R18] Read data captured on final falling edge.
// [R19] Writes drive all sixteen data lines.
// [R20] Write data half clock after address strobe.
// [R21] Read data strobe with address strobe.
// [R22] Write data strobe one clock after address strobe. Fast-terminated writes end first and never assert it.
// [R23] Acknowledge pair decodes wait, byte, word port.
// [R24] Strobes and data released before next cycle.
module ebm_bus_master
  import ebm_pkg::*;
#(
  parameter int HALF_CYC = BUS_HALF_CYC
) (
  input  logic        i_sys_clk,
  input  logic        i_sys_rst,
  // Operand request from the processor core.
  input  logic        i_req_valid,
  output logic        o_req_ready,
  input  logic [31:0] i_req_addr,
  input  logic [1:0]  i_req_size,
  input  logic        i_req_write,
  input  logic [31:0] i_req_wdata,
  input  logic        i_req_super,
  input  logic        i_req_prog,
  input  logic        i_req_control,
  input  logic        i_req_lock,
  input  logic        i_req_lock_last,
  // Operand answer.
  output logic        o_rsp_valid,
  output logic        o_rsp_err,
  output logic [31:0] o_rsp_rdata,
  // Mode inputs from the same clock domain.
  input  logic        i_sync_mode,
  input  logic        i_fast_term,
  input  logic        i_fast_port8,
  // External bus pins.
  output logic        o_bus_clk,
  output logic [31:0] o_addr,
  output logic [2:0]  o_space_code,
  output logic        o_xfer_size_hi,
  output logic        o_xfer_size_lo,
  output logic        o_rd_wr,
  output logic        o_address_strobe_n,
  output logic        o_data_strobe_n,
  output logic        o_locked_rmw_n,
  output logic [15:0] o_data_out,
  output logic        o_data_oe,
  input  logic [15:0] i_data_in,
  input  logic        i_ack_word_port_n,
  input  logic        i_ack_byte_port_n
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int HW         = $clog2(HALF_CYC + 1);  // Divider width.
  localparam int AS_DS_LAG  = 2 * HALF_CYC;          // Write strobe lag.

  ebm_state_t  st_reg;          // Current half-clock state.
  logic [HW-1:0] div_reg;       // Half bus clock divider.
  logic        hen;             // One-cycle half-clock enable.
  logic        fe;              // Falling bus clock edge enable.
  logic        bus_clk_reg;     // Bus clock level.
  logic [1:0]  ack_sync;        // Synchronised acknowledge pair.
  logic [15:0] data_sync;       // Synchronised data bus.
  logic [1:0]  ack_fe_reg;      // Acknowledge sampled at last falling edge.
  logic [1:0]  ack_use;         // Acknowledge used for the decision.
  logic        acc;             // Request accepted this cycle.
  logic        misalign;        // Request refused for alignment or for size SZ_THREE.
  logic        term_now;        // Cycle terminates this cycle.
  logic        port8_now;       // Terminating port is 8 bits.
  logic        last_cyc;        // Terminating cycle ends the operand.
  logic        fast_reg;        // Fast termination latched at start.
  logic [2:0]  rem_reg;         // Bytes still to move.
  logic [2:0]  rem_init;        // Byte count of a new operand.
  logic [31:0] addr_reg;        // Address of the current cycle.
  logic [31:0] wbuf_reg;        // Write bytes, left aligned.
  logic [31:0] rdata_reg;       // Read bytes, assembled.
  logic [31:0] rdata_next;      // Read bytes after this cycle.
  logic        rw_reg;          // Direction, high for read.
  logic [2:0]  space_reg;       // Address space code.
  logic        lock_n_reg;      // Locked sequence output.
  logic        lock_last_reg;   // Operand closes the locked sequence.
  logic        as_n_reg;        // Address strobe.
  logic        ds_n_reg;        // Data strobe.
  logic        oe_reg;          // Write data enable.
  logic [15:0] dout_reg;        // Write data lanes.
  logic        rsp_valid_reg;   // Answer pulse.
  logic        rsp_err_reg;     // Answer refused.
  logic [31:0] rsp_rdata_reg;   // Answer read data.
  logic [2:0]  hc_reg;          // Half clocks since cycle start.
  logic        waited_reg;      // Wait state seen in this cycle.

  ebm_xfer_if xif ();

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Size code and byte count of the running cycle.
  ebm_size_calc u_calc (
    .x (xif.calc)
  );

  // Pins are resolved to clean levels before use.
  // [R9] clean level resolution
  ebm_in_sync #(.W(18)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_ack_word_port_n, i_ack_byte_port_n, i_data_in}),
    .i_rst_val ({ACK_NONE, 16'h0000}),
    .o_sync    ({ack_sync, data_sync})
  );

  // ---------------------------------------------------------------
  // Bus clock divider
  // ---------------------------------------------------------------
  assign hen = (div_reg == HW'(HALF_CYC - 1));
  assign fe  = hen && bus_clk_reg;

  // Counts system cycles per half bus clock and toggles the clock.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      div_reg     <= '0;
      bus_clk_reg <= 1'b0;
    end else if (hen) begin
      div_reg     <= '0;
      bus_clk_reg <= ~bus_clk_reg;
    end else begin
      div_reg     <= div_reg + HW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Acknowledge sampling and decode
  // ---------------------------------------------------------------
  // Keeps the acknowledge level seen at each falling edge.
  // [R8] falling edge sampling
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ack_fe_reg <= ACK_NONE;
    end else if (fe) begin
      ack_fe_reg <= ack_sync;
    end
  end

  // [R5] asynchronous extra stage
  assign ack_use = i_sync_mode ? ack_sync : ack_fe_reg;

  // Termination by the slave, or by fast chip-select timing.
  // [R23] acknowledge decode
  assign port8_now = (st_reg == ST_S2) ? i_fast_port8 : (ack_use == ACK_BYTE_PORT);
  // [R4] slave ends cycle
  assign term_now  = hen && (((st_reg == ST_S2) && fast_reg) ||
                             ((st_reg == ST_S4) && (ack_use != ACK_NONE)));
  assign last_cyc  = (rem_reg == xif.moved);

  // ---------------------------------------------------------------
  // Request acceptance
  // ---------------------------------------------------------------
  // A request starts only just before a rising bus clock edge.
  assign o_req_ready = (st_reg == ST_IDLE) && hen && !bus_clk_reg;
  assign acc         = i_req_valid && o_req_ready;
  // [R1] even alignment only
  assign misalign    = (i_req_size == SZ_THREE) || ((i_req_size != SZ_BYTE) && i_req_addr[0]);

  // Byte count of an operand from its size code.
  always_comb begin
    case (i_req_size)
      SZ_BYTE: rem_init = 3'h1;
      SZ_WORD: rem_init = 3'h2;
      default: rem_init = 3'h4;
    endcase
  end

  // ---------------------------------------------------------------
  // Cycle state machine
  // ---------------------------------------------------------------
  // Steps through half clocks; wait states repeat the S3/S4 pair.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_reg <= ST_IDLE;
    end else if (hen) begin
      case (st_reg)
        ST_IDLE: begin
          if (acc && !misalign) begin
            st_reg <= ST_S0;
          end
        end
        ST_S0: st_reg <= ST_S1;
        ST_S1: st_reg <= ST_S2;
        // [R7] two clock fast path
        ST_S2: st_reg <= fast_reg ? ST_S5 : ST_S3;
        ST_S3: st_reg <= ST_S4;
        // [R6] three clock cycle
        ST_S4: st_reg <= term_now ? ST_S5 : ST_S3;
        // [R2] split into cycles
        ST_S5: st_reg <= (rem_reg != 3'h0) ? ST_S0 : ST_IDLE;
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Operand progress
  // ---------------------------------------------------------------
  assign xif.rem   = rem_reg;
  assign xif.a0    = addr_reg[0];
  assign xif.port8 = port8_now;

  // Appends the bytes of this cycle to the read operand.
  always_comb begin
    if (xif.moved == 3'h2) begin
      rdata_next = {rdata_reg[15:0], data_sync};
    end else if (!port8_now && addr_reg[0]) begin
      rdata_next = {rdata_reg[23:0], data_sync[7:0]};
    end else begin
      rdata_next = {rdata_reg[23:0], data_sync[15:8]};
    end
  end

  // Loads a new operand and advances address and counts per cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rem_reg   <= 3'h0;
      addr_reg  <= 32'h0000_0000;
      wbuf_reg  <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      fast_reg  <= 1'b0;
    end else if (acc && !misalign) begin
      rem_reg   <= rem_init;
      addr_reg  <= i_req_addr;
      rdata_reg <= 32'h0000_0000;
      fast_reg  <= i_fast_term;
      case (i_req_size)
        SZ_BYTE: wbuf_reg <= {i_req_wdata[7:0], 24'h000000};
        SZ_WORD: wbuf_reg <= {i_req_wdata[15:0], 16'h0000};
        default: wbuf_reg <= i_req_wdata;
      endcase
    end else if (term_now) begin
      // [R18] final edge capture
      rdata_reg <= rdata_next;
      rem_reg   <= rem_reg - xif.moved;
      addr_reg  <= addr_reg + {29'h0, xif.moved};
      wbuf_reg  <= (xif.moved == 3'h2) ? {wbuf_reg[15:0], 16'h0000} :
                                          {wbuf_reg[23:0], 8'h00};
    end else if (hen && (st_reg == ST_S5)) begin
      fast_reg  <= i_fast_term;
    end
  end

  // ---------------------------------------------------------------
  // Direction, space and lock
  // ---------------------------------------------------------------
  // Direction loads only when an operand starts, so it holds across
  // runs of same-direction cycles.
  // [R12] direction held
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rw_reg <= 1'b1;
    end else if (acc && !misalign) begin
      rw_reg <= !i_req_write;
    end
  end

  // Space code from privilege and access kind.
  // [R14] space code select
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      space_reg <= RST_SPACE;
    end else if (acc && !misalign) begin
      if (i_req_control) begin
        space_reg <= SPC_CONTROL;
      // [R15] privilege chooses space
      end else if (i_req_super) begin
        space_reg <= i_req_prog ? SPC_SUP_PROG : SPC_SUP_DATA;
      end else begin
        space_reg <= i_req_prog ? SPC_USER_PROG : SPC_USER_DATA;
      end
    end
  end

  // Lock asserts at the first cycle and stays until the closing
  // operand's final cycle ends.
  // [R13] locked sequence span
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      lock_n_reg    <= 1'b1;
      lock_last_reg <= 1'b0;
    end else if (acc && !misalign) begin
      lock_last_reg <= i_req_lock && i_req_lock_last;
      if (i_req_lock) begin
        lock_n_reg <= 1'b0;
      end
    end else if (term_now && last_cyc && lock_last_reg) begin
      lock_n_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Strobes and write data
  // ---------------------------------------------------------------
  // Address strobe half a clock after start; read data strobe with it;
  // write data strobe one clock later except on fast-terminated writes; all released at termination.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      as_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
    end else if (term_now) begin
      // [R24] release before next
      as_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
    end else if (hen && (st_reg == ST_S0)) begin
      // [R17] strobe after half clock
      as_n_reg <= 1'b0;
      // [R21] read strobes together
      ds_n_reg <= !rw_reg;
    end else if (hen && !rw_reg && (st_reg == ST_S2)) begin
      // [R22] write strobe lag
      ds_n_reg <= 1'b0;
    end
  end

  // Write lanes drive all sixteen lines half a clock after the
  // address strobe; a single byte is copied onto both lanes.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      oe_reg   <= 1'b0;
      dout_reg <= 16'h0000;
    end else if (term_now) begin
      oe_reg   <= 1'b0;
    end else if (hen && !rw_reg && (st_reg == ST_S1)) begin
      // [R20] write data timing
      oe_reg   <= 1'b1;
      // [R19] all lines driven
      dout_reg <= (rem_reg == 3'h1) ? {wbuf_reg[31:24], wbuf_reg[31:24]} : wbuf_reg[31:16];
    end
  end

  // ---------------------------------------------------------------
  // Operand answer
  // ---------------------------------------------------------------
  // One-cycle answer at operand end, or at once when refused.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_err_reg   <= 1'b0;
      rsp_rdata_reg <= 32'h0000_0000;
    end else begin
      rsp_valid_reg <= (acc && misalign) || (term_now && last_cyc);
      rsp_err_reg   <= acc && misalign;
      if (term_now && last_cyc) begin
        rsp_rdata_reg <= rdata_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // [R10] cycle outputs driven
  // [R11] size code output
  // [R16] address output
  assign o_bus_clk          = bus_clk_reg;
  assign o_addr             = addr_reg;
  assign o_space_code       = space_reg;
  assign o_xfer_size_hi     = xif.size_code[1];
  assign o_xfer_size_lo     = xif.size_code[0];
  assign o_rd_wr            = rw_reg;
  assign o_address_strobe_n = as_n_reg;
  assign o_data_strobe_n    = ds_n_reg;
  assign o_locked_rmw_n     = lock_n_reg;
  assign o_data_out         = dout_reg;
  assign o_data_oe          = oe_reg;
  assign o_rsp_valid        = rsp_valid_reg;
  assign o_rsp_err          = rsp_err_reg;
  assign o_rsp_rdata        = rsp_rdata_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Half clocks since start and wait states, for cycle length checks.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || (hen && (st_reg == ST_S5))) begin
      hc_reg     <= 3'h0;
      waited_reg <= 1'b0;
    end else if (hen && (st_reg != ST_IDLE)) begin
      hc_reg     <= hc_reg + 3'h1;
      waited_reg <= waited_reg || ((st_reg == ST_S4) && !term_now);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_as_fall_rd;
    $fell(o_address_strobe_n) && o_rd_wr;
  endsequence

  sequence s_as_fall_wr;
    $fell(o_address_strobe_n) && !o_rd_wr && !fast_reg;
  endsequence

  AST_ODD_REFUSED: assert property ( // [R1]
    acc && (i_req_size != SZ_BYTE) && i_req_addr[0] |=> o_rsp_err && (st_reg == ST_IDLE))
    else $error("misaligned operand started a bus cycle");
  AST_SPLIT_NEXT: assert property ( // [R2]
    hen && (st_reg == ST_S5) && (rem_reg != 3'h0) |=> (st_reg == ST_S0))
    else $error("remaining bytes did not start another cycle");
  AST_THREE_CLK: assert property ( // [R6]
    term_now && (st_reg == ST_S4) && i_sync_mode && !waited_reg |-> (hc_reg == 3'h4))
    else $error("synchronous cycle longer than three clocks");
  AST_FAST_TWO: assert property ( // [R7]
    term_now && (st_reg == ST_S2) |-> (hc_reg == 3'h2) && !o_address_strobe_n)
    else $error("fast termination not at two clocks");
  AST_SIZE_CODE: assert property ( // [R11]
    !o_address_strobe_n |-> ({o_xfer_size_hi, o_xfer_size_lo} == rem_reg[1:0]) && (rem_reg != 3'h0))
    else $error("size code does not match remaining bytes");
  AST_ADDR_STABLE: assert property ( // [R16]
    !o_address_strobe_n && !$past(o_address_strobe_n) |-> $stable(o_addr) && $stable(o_space_code))
    else $error("address moved while strobe active");
  AST_RW_CHANGE: assert property ( // [R12]
    $changed(o_rd_wr) |-> o_address_strobe_n && ($past(st_reg) == ST_IDLE))
    else $error("direction changed outside cycle start");
  AST_AS_HALF: assert property ( // [R17]
    hen && (st_reg == ST_S0) |=> !o_address_strobe_n && !o_bus_clk)
    else $error("address strobe not at half clock");
  AST_READ_DS: assert property ( // [R21]
    s_as_fall_rd |-> $fell(o_data_strobe_n) && !o_data_oe)
    else $error("read data strobe not with address strobe");
  AST_WRITE_DS: assert property ( // [R22]
    s_as_fall_wr |-> o_data_strobe_n ##AS_DS_LAG $fell(o_data_strobe_n))
    else $error("write data strobe not one clock late");
  AST_WDATA: assert property ( // [R20]
    $fell(o_address_strobe_n) && !o_rd_wr |-> !o_data_oe ##HALF_CYC $rose(o_data_oe))
    else $error("write data not half clock after strobe");
  AST_RELEASE: assert property ( // [R24]
    (st_reg == ST_S0) |-> o_address_strobe_n && o_data_strobe_n && !o_data_oe)
    else $error("strobes or data still active at cycle start");
  AST_LOCK_START: assert property ( // [R13]
    $fell(o_locked_rmw_n) |-> (st_reg == ST_S0) && o_address_strobe_n)
    else $error("lock asserted outside a cycle start");

endmodule // ebm_bus_master

// File: dv/ebm_slave.sv
// Behavioural memory or peripheral on the far side of the bus.
`timescale 1ns/1ns
module ebm_slave (
  input  wire logic        i_sys_clk,
  input  wire logic        i_as_n,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_port8,
  input  wire logic [7:0]  i_dly,
  output logic             o_ack_word_n,
  output logic             o_ack_byte_n,
  output logic [15:0]      o_data
);
  logic [7:0]  cnt_reg;               // Cycles the address strobe has been low.
  logic [7:0]  a;                     // Each byte holds its own low address.
  logic [15:0] last_reg = 16'h0000;   // Last value driven, for the released bus.
  assign a = i_addr[7:0];
  // Count the wait so the cycle length is ours to choose.
  always_ff @(posedge i_sys_clk) cnt_reg <= i_as_n ? 8'h00 : cnt_reg + 8'h01;
  assign o_ack_word_n = i_as_n || (cnt_reg < i_dly) || i_port8;
  assign o_ack_byte_n = i_as_n || (cnt_reg < i_dly) || !i_port8;
  // A released bus shows the inverse of its last value, never a stale copy.
  always_ff @(posedge i_sys_clk) if (!i_as_n) last_reg <= o_data;
  assign o_data = i_as_n ? ~last_reg : (i_port8 ? {a, ~a} : {a & 8'hFE, a | 8'h01});
endmodule // ebm_slave

// File: dv/testbench.sv
// Self-checking bench of the bus-master cycle sequencer.
`timescale 1ns/1ns
module testbench;
  import ebm_pkg::*;
  logic clk = 0, rst = 1, valid = 0, wr = 0, sup = 0, prog = 0, syn = 1, p8 = 0, ctl = 0;
  logic lock = 0, last = 0, fast = 0, fp8 = 0, ds_q = 1;
  logic [31:0] addr = 0, wd;
  logic [1:0] size = 0, sz, bc;
  logic [2:0] sp;
  logic [7:0] dly = 0;
  logic as_q = 1, rw, oe_seen;
  int ncyc, err_count = 0, compares = 0, cyc = 0;
  wire ready, rv, re, asn, ackw, ackb, oe, dsn, lk, bclk;
  wire [31:0] rd, a_o;
  wire [15:0] din, dout;
  wire [2:0] spc;
  wire shi, slo, rwo;
  ebm_bus_master #(.HALF_CYC(4)) i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_req_valid(valid),
    .o_req_ready(ready), .i_req_addr(addr), .i_req_size(size), .i_req_write(wr),
    .i_req_wdata(32'hA1B2C3D4), .i_req_super(sup), .i_req_prog(prog), .i_req_control(ctl),
    .i_req_lock(lock), .i_req_lock_last(last), .o_rsp_valid(rv), .o_rsp_err(re), .o_rsp_rdata(rd),
    .i_sync_mode(syn), .i_fast_term(fast), .i_fast_port8(fp8), .o_bus_clk(bclk), .o_addr(a_o),
    .o_space_code(spc), .o_xfer_size_hi(shi), .o_xfer_size_lo(slo), .o_rd_wr(rwo),
    .o_address_strobe_n(asn), .o_data_strobe_n(dsn), .o_locked_rmw_n(lk), .o_data_out(dout),
    .o_data_oe(oe), .i_data_in(din), .i_ack_word_port_n(ackw), .i_ack_byte_port_n(ackb));
  ebm_slave i_mem (.i_sys_clk(clk), .i_as_n(asn), .i_addr(a_o), .i_port8(p8), .i_dly(dly),
    .o_ack_word_n(ackw), .o_ack_byte_n(ackb), .o_data(din));
  initial forever #5 clk = ~clk;
  // Count bus cycles and keep what the first one showed.
  always @(posedge clk) begin
    as_q <= asn;
    ds_q <= dsn;
    // Write lanes as the data strobe falls, oldest first.
    if (ds_q && !dsn && !rwo) wd <= {wd[15:0], dout};
    if (oe === 1'b1 && !oe_seen) bc[1] = bclk;
    if (oe === 1'b1) oe_seen = 1;
    if (as_q && !asn) begin
      if (ncyc == 0) begin
        bc[0] = bclk;
        sz = {shi, slo};
        sp = spc;
        rw = rwo;
      end
      ncyc++;
    end
  end
  task automatic results();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // One operand: hold the request until taken, then wait for the answer.
  // Mode bits m: sync, program, control, lock, lock last, fast, fast byte port.
  task automatic op(logic [31:0] ad, logic [1:0] s, logic w, logic su, logic [6:0] m);
    ncyc = 0;
    oe_seen = 0;
    @(posedge clk);
    valid <= 1; addr <= ad; size <= s; wr <= w; sup <= su;
    {syn, prog, ctl, lock, last, fast, fp8} <= m;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    valid <= 0;
    do @(negedge clk); while (rv !== 1'b1);
  endtask
  task automatic t_word_read();
    op(32'h12, SZ_WORD, 0, 0, 7'h40);
    chk("rdata", rd[15:0], 16'h1213);
    chk("cycles", ncyc, 1);
    chk("space", sp, SPC_USER_DATA);
    chk("size", sz, SZ_WORD);
  endtask
  task automatic t_long_byte_port();
    p8 = 1;
    op(32'h20, SZ_LONG, 0, 1, 7'h40);
    chk("rdata", rd, 32'h20212223);
    chk("cycles", ncyc, 4);
    chk("space", sp, SPC_SUP_DATA);
    chk("size", sz, SZ_LONG);
    p8 = 0;
  endtask
  task automatic t_long_write();
    op(32'h40, SZ_LONG, 1, 0, 7'h40);
    chk("cycles", ncyc, 2);
    chk("rd_wr", rw, 0);
    chk("oe", oe_seen, 1);
    chk("wdata", wd, 32'hA1B2C3D4);
    chk("bus_clk", bc, 2'h2);
  endtask
  task automatic t_odd();
    op(32'h33, SZ_WORD, 0, 0, 7'h40);
    chk("err", re, 1);
    chk("cycles", ncyc, 0);
    op(32'h34, SZ_THREE, 0, 0, 7'h40);
    chk("err3", re, 1);
    op(32'h33, SZ_BYTE, 0, 0, 7'h60);
    chk("byte", rd[7:0], 8'h33);
    chk("space", sp, SPC_USER_PROG);
  endtask
  task automatic t_slow_async();
    dly = 8'd60;
    op(32'h12, SZ_WORD, 0, 0, 7'h00);
    chk("slow", rd[15:0], 16'h1213);
    chk("cycles", ncyc, 1);
    dly = 0;
  endtask
  // Fast termination on a word port, then on a byte port in control space.
  task automatic t_fast();
    op(32'h12, SZ_WORD, 0, 0, 7'h42);
    chk("fast", rd[15:0], 16'h1213);
    p8 = 1;
    op(32'h20, SZ_LONG, 0, 0, 7'h53);
    chk("fast8", rd, 32'h20212223);
    chk("cycles", ncyc, 4);
    chk("space", sp, SPC_CONTROL);
    p8 = 0;
  endtask
  // Locked read then closing write; lock holds between the two.
  task automatic t_lock();
    op(32'h50, SZ_WORD, 0, 0, 7'h48);
    chk("lock", lk, 0);
    op(32'h50, SZ_WORD, 1, 0, 7'h4C);
    chk("unlock", lk, 1);
    chk("rd_wr", rw, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_word_read();
    t_long_byte_port();
    t_long_write();
    t_odd();
    t_slow_async();
    t_fast();
    t_lock();
    results();
  end
endmodule // testbench
